// file: design/tcfc_timer.sv
// Purpose: compare force, channel 7 override, free-running count and system control
// Assumes: classic Wishbone slave, one register per 32-bit word, data in bits 7:0
// Notes: compare action is a toggle on channels whose connect bit is set
//
// Contract
// - force bit write performs channel compare action at once, flag untouched
// - force register always reads as zero
// - channel 7 override beats simultaneous channel 0..6 compare actions
// - force coinciding with real match applies action and leaves flag clear
// - override mask bit on output compare channel makes its pin an output
// - channel 7 event copies masked override data bits to port data
// - main counter is sixteen bits and counts only upward
// - counter writes ignored unless test mode is one
// - first count after counter write may be short, never longer than a full prescale period
// - run enable zero halts main timer including counter; accumulator input edges still count
// - no divide-by-64 tick to accumulator while timer inactive
// - stop-in-wait halts timer and accumulator during wait mode
// - stop-in-freeze halts counter in freeze; accumulator keeps running
// - fast clear: capture read or compare write clears channel flag
// - fast clear: any counter byte access clears counter wrap flag
// - fast clear: accumulator count access clears both accumulator flags
// - direction bit one means output compare, zero input capture
`timescale 1ns/100ps
`include "tcfc_consts.svh"

module tcfc_timer
  import tcfc_pkg::*;
#(
  parameter logic [7:0] PRESCALE_DIV = `TCFC_PRESCALE_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic test_mode,
  input wire logic wait_mode,
  input wire logic freeze_mode,
  input wire logic [7:0] capture_in,
  input wire logic accum_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  output logic accum_div64_tick,
  output logic irq
);

  tcfc_state_type s_q;
  tcfc_state_type s_d;

  function automatic logic tcfc_hit(input logic [5:0] idx, input logic [5:0] reg_idx);
    tcfc_hit = (idx == reg_idx);
  endfunction : tcfc_hit

  logic access;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic cmp_range;
  logic [2:0] cmp_ch;
  logic active;
  logic cnt_active;
  logic acc_active;
  logic cnt_tick;
  logic [7:0] force_pulse;
  logic [7:0] match;
  logic [7:0] ev;
  logic [7:0] cap_edge;
  logic [7:0] ch_set;
  logic [7:0] ch_clr;
  logic wrap_set;
  logic wrap_clr;
  logic acc_ovf_set;
  logic acc_edge_set;
  logic acc_clr_ovf;
  logic acc_clr_edge;
  logic cnt_access;
  logic acc_access;

  always_comb begin
    s_d = s_q;
    access = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = access & wb_we_i & wb_sel_i[0];
    rd = access & ~wb_we_i;
    idx = wb_adr_i[7:2];
    cmp_range = (idx >= `TCFC_IDX_CMP_FIRST) && (idx <= `TCFC_IDX_CMP_LAST);
    cmp_ch = idx[3:1];
    s_d.ack = access;

    // activity gating of timer, counter and accumulator
    active = s_q.run & ~(s_q.stop_wait & wait_mode);
    cnt_active = active & ~(s_q.stop_frz & freeze_mode);
    acc_active = ~(s_q.stop_wait & wait_mode);

    // prescaler; a counter write does not realign it
    cnt_tick = 1'b0;
    if (cnt_active) begin
      if (s_q.div >= PRESCALE_DIV - 8'h01) begin
        s_d.div = 8'h00;
        cnt_tick = 1'b1;
      end else begin
        s_d.div = s_q.div + 8'h01;
      end
    end
    s_d.acc_tick = 1'b0;
    if (active) begin
      s_d.pre64 = s_q.pre64 + 6'h01;
      s_d.acc_tick = (s_q.pre64 == `TCFC_DIV64_LAST);
    end

    force_pulse = 8'h00;
    if (wr && tcfc_hit(idx, `TCFC_IDX_FORCE)) begin
      force_pulse = wb_dat_i[7:0] & s_q.dir;
    end
    for (int i = 0; i < 8; i++) begin
      match[i] = cnt_tick & s_q.dir[i] & (s_q.cnt == s_q.cmp[i]);
      cap_edge[i] = ~s_q.dir[i] & active & capture_in[i] & ~s_q.cap_prev[i];
    end
    ev = force_pulse | match;
    ch_set = (match & ~force_pulse) | cap_edge;

    // compare output actions, channel 7 override first
    for (int i = 0; i < 8; i++) begin
      if (ev[7] && s_q.omask[i]) begin
        s_d.port[i] = s_q.odata[i];
      end else if (ev[i] && s_q.connect[i]) begin
        s_d.port[i] = ~s_q.port[i];
      end
      s_d.oe[i] = s_q.dir[i] & (s_q.omask[i] | s_q.connect[i]);
    end
    s_d.cap_prev = capture_in;

    // capture latches the count
    for (int i = 0; i < 8; i++) begin
      if (cap_edge[i]) begin
        s_d.cmp[i] = s_q.cnt;
      end
    end

    // free-running count
    wrap_set = 1'b0;
    if (cnt_tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;
      wrap_set = (s_q.cnt == `TCFC_CNT_MAX);
    end
    if (wr && test_mode && tcfc_hit(idx, `TCFC_IDX_CNT_HI)) begin
      s_d.cnt[15:8] = wb_dat_i[7:0];
    end
    if (wr && test_mode && tcfc_hit(idx, `TCFC_IDX_CNT_LO)) begin
      s_d.cnt[7:0] = wb_dat_i[7:0];
    end

    // pulse accumulator counts rising edges of its input
    acc_edge_set = acc_active & accum_in & ~s_q.acc_prev;
    acc_ovf_set = 1'b0;
    s_d.acc_prev = accum_in;
    if (acc_edge_set) begin
      s_d.acc_cnt = s_q.acc_cnt + 16'h0001;
      acc_ovf_set = (s_q.acc_cnt == `TCFC_CNT_MAX);
    end
    if (wr && tcfc_hit(idx, `TCFC_IDX_ACC_HI)) begin
      s_d.acc_cnt[15:8] = wb_dat_i[7:0];
    end
    if (wr && tcfc_hit(idx, `TCFC_IDX_ACC_LO)) begin
      s_d.acc_cnt[7:0] = wb_dat_i[7:0];
    end

    // control and data registers
    if (wr) begin
      case (idx)
        `TCFC_IDX_DIR: s_d.dir = wb_dat_i[7:0];
        `TCFC_IDX_OMASK: s_d.omask = wb_dat_i[7:0];
        `TCFC_IDX_ODATA: s_d.odata = wb_dat_i[7:0];
        `TCFC_IDX_CONNECT: s_d.connect = wb_dat_i[7:0];
        `TCFC_IDX_IMASK: s_d.imask = wb_dat_i[8:0];
        `TCFC_IDX_SYSCTL: begin
          s_d.run = wb_dat_i[`TCFC_SYS_RUN_BIT];
          s_d.stop_wait = wb_dat_i[`TCFC_SYS_WAIT_BIT];
          s_d.stop_frz = wb_dat_i[`TCFC_SYS_FRZ_BIT];
          s_d.fast_clr = wb_dat_i[`TCFC_SYS_FAST_BIT];
        end
        default: begin
        end
      endcase
    end
    // compare values take writes only while the channel is an output compare
    if (wr && cmp_range && s_q.dir[cmp_ch]) begin
      if (idx[0]) begin
        s_d.cmp[cmp_ch][7:0] = wb_dat_i[7:0];
      end else begin
        s_d.cmp[cmp_ch][15:8] = wb_dat_i[7:0];
      end
    end

    // flag clearing: write one, or fast clear on access
    ch_clr = 8'h00;
    wrap_clr = 1'b0;
    acc_clr_ovf = 1'b0;
    acc_clr_edge = 1'b0;
    if (wr && tcfc_hit(idx, `TCFC_IDX_CHFLAG)) begin
      ch_clr = wb_dat_i[7:0];
    end
    if (wr && tcfc_hit(idx, `TCFC_IDX_WRAPFLAG)) begin
      wrap_clr = wb_dat_i[`TCFC_WRAP_BIT];
    end
    if (wr && tcfc_hit(idx, `TCFC_IDX_ISTAT)) begin
      ch_clr = ch_clr | wb_dat_i[7:0];
      wrap_clr = wrap_clr | wb_dat_i[8];
    end
    if (wr && tcfc_hit(idx, `TCFC_IDX_ACC_FLAG)) begin
      acc_clr_ovf = wb_dat_i[`TCFC_ACC_OVF_BIT];
      acc_clr_edge = wb_dat_i[`TCFC_ACC_EDGE_BIT];
    end
    cnt_access = access & (tcfc_hit(idx, `TCFC_IDX_CNT_HI) | tcfc_hit(idx, `TCFC_IDX_CNT_LO));
    acc_access = access & (tcfc_hit(idx, `TCFC_IDX_ACC_HI) | tcfc_hit(idx, `TCFC_IDX_ACC_LO));
    if (s_q.fast_clr) begin
      if (rd && cmp_range && !s_q.dir[cmp_ch]) begin
        ch_clr[cmp_ch] = 1'b1;
      end
      if (wr && cmp_range && s_q.dir[cmp_ch]) begin
        ch_clr[cmp_ch] = 1'b1;
      end
      if (cnt_access) begin
        wrap_clr = 1'b1;
      end
      if (acc_access) begin
        acc_clr_ovf = 1'b1;
        acc_clr_edge = 1'b1;
      end
    end
    // a set in the same cycle as a clear wins
    s_d.chflag = (s_q.chflag & ~ch_clr) | ch_set;
    s_d.wrap = (s_q.wrap & ~wrap_clr) | wrap_set;
    s_d.acc_ovf = (s_q.acc_ovf & ~acc_clr_ovf) | acc_ovf_set;
    s_d.acc_edge = (s_q.acc_edge & ~acc_clr_edge) | acc_edge_set;
    s_d.irq = |({s_d.wrap, s_d.chflag} & s_d.imask);

    // read data
    s_d.rdata = 8'h00;
    if (rd) begin
      case (idx)
        `TCFC_IDX_DIR: s_d.rdata = s_q.dir;
        `TCFC_IDX_FORCE: s_d.rdata = `TCFC_RST_BYTE;
        `TCFC_IDX_OMASK: s_d.rdata = s_q.omask;
        `TCFC_IDX_ODATA: s_d.rdata = s_q.odata;
        `TCFC_IDX_CNT_HI: s_d.rdata = s_q.cnt[15:8];
        `TCFC_IDX_CNT_LO: s_d.rdata = s_q.cnt[7:0];
        `TCFC_IDX_SYSCTL: s_d.rdata = {s_q.run, s_q.stop_wait, s_q.stop_frz, s_q.fast_clr, 4'h0};
        `TCFC_IDX_CHFLAG: s_d.rdata = s_q.chflag;
        `TCFC_IDX_WRAPFLAG: s_d.rdata = {s_q.wrap, 7'h00};
        `TCFC_IDX_ACC_FLAG: s_d.rdata = {6'h00, s_q.acc_ovf, s_q.acc_edge};
        `TCFC_IDX_ACC_HI: s_d.rdata = s_q.acc_cnt[15:8];
        `TCFC_IDX_ACC_LO: s_d.rdata = s_q.acc_cnt[7:0];
        `TCFC_IDX_IMASK: s_d.rdata = s_q.imask[7:0];
        `TCFC_IDX_ISTAT: s_d.rdata = s_q.chflag;
        `TCFC_IDX_CONNECT: s_d.rdata = s_q.connect;
        default: begin
          if (cmp_range) begin
            s_d.rdata = idx[0] ? s_q.cmp[cmp_ch][7:0] : s_q.cmp[cmp_ch][15:8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // bit 8 of mask and status is write-only and reads as zero
  assign wb_dat_o = {24'h000000, s_q.rdata};
  assign wb_ack_o = s_q.ack;
  assign port_out = s_q.port;
  assign port_oe = s_q.oe;
  assign accum_div64_tick = s_q.acc_tick;
  assign irq = s_q.irq;

endmodule : tcfc_timer

// file: shared/tcfc_consts.svh
// Purpose: register indices, field positions and reset values of the timer block
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef TCFC_CONSTS_SVH
`define TCFC_CONSTS_SVH

`define TCFC_IDX_DIR 6'h00
`define TCFC_IDX_FORCE 6'h01
`define TCFC_IDX_OMASK 6'h02
`define TCFC_IDX_ODATA 6'h03
`define TCFC_IDX_CNT_HI 6'h04
`define TCFC_IDX_CNT_LO 6'h05
`define TCFC_IDX_SYSCTL 6'h06
`define TCFC_IDX_CHFLAG 6'h0e
`define TCFC_IDX_WRAPFLAG 6'h0f
`define TCFC_IDX_CMP_FIRST 6'h10
`define TCFC_IDX_CMP_LAST 6'h1f
`define TCFC_IDX_ACC_FLAG 6'h21
`define TCFC_IDX_ACC_HI 6'h22
`define TCFC_IDX_ACC_LO 6'h23
`define TCFC_IDX_IMASK 6'h30
`define TCFC_IDX_ISTAT 6'h31
`define TCFC_IDX_CONNECT 6'h32

`define TCFC_SYS_RUN_BIT 7
`define TCFC_SYS_WAIT_BIT 6
`define TCFC_SYS_FRZ_BIT 5
`define TCFC_SYS_FAST_BIT 4
`define TCFC_WRAP_BIT 7
`define TCFC_ACC_OVF_BIT 1
`define TCFC_ACC_EDGE_BIT 0

`define TCFC_RST_BYTE 8'h00
`define TCFC_RST_WORD 16'h0000
`define TCFC_CNT_MAX 16'hffff
`define TCFC_DIV64_LAST 6'h3f
`define TCFC_PRESCALE_DEF 8'h01

`endif

// file: shared/tcfc_pkg.sv
// Purpose: types of the timer compare, force and control block
// Assumes: constants come from tcfc_consts.svh
// Notes: the whole block state is one packed struct
package tcfc_pkg;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] dir;
    logic [7:0] omask;
    logic [7:0] odata;
    logic [7:0] connect;
    logic [8:0] imask;
    logic run;
    logic stop_wait;
    logic stop_frz;
    logic fast_clr;
    logic [15:0] cnt;
    logic [7:0] div;
    logic [5:0] pre64;
    logic [7:0] chflag;
    logic wrap;
    logic [7:0][15:0] cmp;
    logic [7:0] cap_prev;
    logic [15:0] acc_cnt;
    logic acc_prev;
    logic acc_ovf;
    logic acc_edge;
    logic acc_tick;
    logic [7:0] port;
    logic [7:0] oe;
    logic irq;
  } tcfc_state_type;

endpackage : tcfc_pkg

// file: verif/tcfc_timer_properties.sv
// Purpose: port checks of the timer block
// Assumes: a write takes effect at the edge that takes it, sel[0] high
// Notes: shadow copies of the control registers the checks need
`timescale 1ns/100ps
`include "tcfc_consts.svh"
module tcfc_timer_properties
  import tcfc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wait_mode,
  input wire logic [7:0] port_oe,
  input wire logic accum_div64_tick,
  input wire logic irq
);
  logic take;
  logic wr;
  logic [7:0] dir_q, om_q, con_q, allow;
  logic [8:0] im_q;
  logic run_q, sw_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign allow = dir_q & (om_q | con_q);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {dir_q, om_q, con_q, im_q, run_q, sw_q} <= '0;
    end else if (wr) begin
      case (wb_adr_i[7:2])
        `TCFC_IDX_DIR: dir_q <= wb_dat_i[7:0];
        `TCFC_IDX_OMASK: om_q <= wb_dat_i[7:0];
        `TCFC_IDX_CONNECT: con_q <= wb_dat_i[7:0];
        `TCFC_IDX_IMASK: im_q <= wb_dat_i[8:0];
        `TCFC_IDX_SYSCTL: {run_q, sw_q} <= wb_dat_i[7:6];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_FORCE_RD0: assert property (take && !wb_we_i && wb_adr_i[7:2] == `TCFC_IDX_FORCE
    |=> wb_dat_o == 32'h0) else $error("force register read not zero");
  AST_TICK_OFF: assert property (!run_q || (sw_q && wait_mode)
    |=> !accum_div64_tick) else $error("tick while timer inactive");
  AST_TICK_GAP: assert property (accum_div64_tick |=> !accum_div64_tick [*8])
    else $error("ticks too close");
  AST_IRQ_MASK: assert property (im_q == 9'h0 && $past(im_q) == 9'h0 |-> !irq)
    else $error("irq with all sources masked");
  AST_OE_MATCH: assert property (allow == $past(allow) |-> port_oe == allow)
    else $error("output enable differs from direction and mask");
endmodule : tcfc_timer_properties

// file: verif/tcfc_port_model.sv
// Purpose: far side of the timer port and accumulator input
// Assumes: a pin driven by the block reads back its own level
// Notes: accumulator edges every four clocks while enabled
`timescale 1ns/100ps
module tcfc_port_model (
  input wire logic clock,
  input wire logic pulse_en,
  input wire logic [7:0] level,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  output logic [7:0] capture_in,
  output logic accum_in
);
  logic [1:0] ph_q = 2'h0;
  assign capture_in = (port_oe & port_out) | (~port_oe & level);
  assign accum_in = ph_q[1];
  always @(posedge clock) begin
    if (pulse_en) ph_q <= ph_q + 2'h1;
  end
endmodule : tcfc_port_model

// file: verif/tcfc_timer_tb_top.sv
// Purpose: self-checking bench of the timer block
// Assumes: prescale of one, so the count steps every clock
// Notes: back-to-back bus reads sample the count three clocks apart
`timescale 1ns/100ps
`include "tcfc_consts.svh"
module tcfc_timer_tb_top
  import tcfc_pkg::*;
;
  logic clock = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, lvl = 8'h00, port_out, port_oe, m, a;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
  logic test_mode = 1'b0, wait_mode = 1'b0, freeze_mode = 1'b0, pen = 1'b0;
  logic wb_ack_o, accum_in, accum_div64_tick, irq;
  logic [7:0] capture_in;
  int fail_count = 0, samples_checked = 0, cyc_n = 0, pm = 0;
  int mdl[64];
  always #25 clock = ~clock;
  tcfc_timer #(.PRESCALE_DIV(8'h01)) i_tcfc_timer (.clock, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .test_mode, .wait_mode,
    .freeze_mode, .capture_in, .accum_in, .port_out, .port_oe, .accum_div64_tick, .irq);
  tcfc_port_model i_tcfc_port_model (.clock, .pulse_en(pen), .level(lvl), .port_out,
    .port_oe, .capture_in, .accum_in);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [5:0] i, input logic [8:0] v);
    int n;
    n = 0;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'h1};
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {23'h0, v};
    do @(posedge clock); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (n == 20) fail_count++;
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (w) mdl[i] = v;
  endtask : xfer
  task automatic rd(input logic [5:0] i, input logic [31:0] exp);
    xfer(1'b0, i, 9'h0);
    check(rdat, exp);
  endtask : rd
  task automatic cnt_step(input logic [7:0] exp);
    xfer(1'b0, `TCFC_IDX_CNT_LO, 9'h0);
    a = rdat[7:0];
    xfer(1'b0, `TCFC_IDX_CNT_LO, 9'h0);
    a = rdat[7:0] - a;
    check(32'(a), 32'(exp));
  endtask : cnt_step
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clock) begin
    if (++cyc_n == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    a = 8'($urandom(32'h23b2));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) rd(i[5:0], 32'h0);
    $display("reset values done");
    xfer(1'b1, `TCFC_IDX_DIR, 9'($urandom()));
    xfer(1'b1, `TCFC_IDX_OMASK, 9'($urandom() & 8'hff));
    xfer(1'b1, `TCFC_IDX_ODATA, 9'($urandom() & 8'hff));
    rd(`TCFC_IDX_OMASK, mdl[2]);
    rd(`TCFC_IDX_DIR, mdl[0] & 8'hff);
    check(32'(port_oe), mdl[0] & mdl[2] & 8'hff);
    rd(6'h3f, 32'h0);
    $display("register test done");
    xfer(1'b1, `TCFC_IDX_DIR, 9'hff);
    xfer(1'b1, `TCFC_IDX_CONNECT, 9'hff);
    xfer(1'b1, `TCFC_IDX_OMASK, 9'h0);
    m = 8'($urandom()) & 8'h7f;
    xfer(1'b1, `TCFC_IDX_FORCE, 9'(m));
    pm = pm ^ m;
    repeat (2) @(posedge clock);
    check(32'(port_out), pm);
    rd(`TCFC_IDX_CHFLAG, 32'h0);
    rd(`TCFC_IDX_FORCE, 32'h0);
    m = 8'($urandom()) | 8'h01;
    xfer(1'b1, `TCFC_IDX_OMASK, 9'(m));
    xfer(1'b1, `TCFC_IDX_FORCE, 9'h81);
    pm = ((pm ^ (8'h81 & ~m)) & ~m & 8'hff) | (mdl[3] & m);
    repeat (2) @(posedge clock);
    check(32'(port_out), pm);
    $display("force test done");
    xfer(1'b1, `TCFC_IDX_CONNECT, 9'h0);
    @(posedge clock) test_mode <= 1'b1;
    xfer(1'b1, `TCFC_IDX_CNT_HI, 9'hff);
    xfer(1'b1, `TCFC_IDX_CNT_LO, 9'hf0);
    @(posedge clock) test_mode <= 1'b0;
    xfer(1'b1, `TCFC_IDX_CNT_LO, 9'h00);
    rd(`TCFC_IDX_CNT_HI, 32'hff);
    rd(`TCFC_IDX_CNT_LO, 32'hf0);
    xfer(1'b1, `TCFC_IDX_IMASK, 9'h100);
    xfer(1'b1, `TCFC_IDX_SYSCTL, 9'h90);
    rd(`TCFC_IDX_SYSCTL, 32'h90);
    repeat (40) @(posedge clock);
    check(32'(irq), 32'h1);
    rd(`TCFC_IDX_WRAPFLAG, 32'h80);
    xfer(1'b1, `TCFC_IDX_IMASK, 9'h0);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0);
    xfer(1'b1, `TCFC_IDX_IMASK, 9'h100);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h1);
    cnt_step(8'h03);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0);
    rd(`TCFC_IDX_WRAPFLAG, 32'h0);
    $display("counter test done");
    xfer(1'b1, `TCFC_IDX_SYSCTL, 9'hd0);
    @(posedge clock) wait_mode <= 1'b1;
    cnt_step(8'h00);
    @(posedge clock) wait_mode <= 1'b0;
    xfer(1'b1, `TCFC_IDX_SYSCTL, 9'hb0);
    @(posedge clock) freeze_mode <= 1'b1;
    cnt_step(8'h00);
    @(posedge clock) pen <= 1'b1;
    repeat (10) @(posedge clock);
    @(posedge clock) pen <= 1'b0;
    repeat (4) @(posedge clock);
    rd(`TCFC_IDX_ACC_FLAG, 32'h1);
    xfer(1'b0, `TCFC_IDX_ACC_HI, 9'h0);
    rd(`TCFC_IDX_ACC_FLAG, 32'h0);
    @(posedge clock) freeze_mode <= 1'b0;
    xfer(1'b1, `TCFC_IDX_DIR, 9'hfe);
    xfer(1'b1, `TCFC_IDX_CHFLAG, 9'hff);
    @(posedge clock) lvl <= 8'h01;
    rd(`TCFC_IDX_CHFLAG, 32'h1);
    xfer(1'b0, `TCFC_IDX_CMP_FIRST, 9'h0);
    rd(`TCFC_IDX_CHFLAG, 32'h0);
    $display("mode test done");
    a = 8'h00;
    repeat (128) @(posedge clock) a = a + 8'(accum_div64_tick);
    check(32'(a), 32'h2);
    xfer(1'b1, `TCFC_IDX_SYSCTL, 9'h0);
    a = 8'h00;
    repeat (70) @(posedge clock) a = a + 8'(accum_div64_tick);
    check(32'(a), 32'h0);
    $display("tick test done");
    tally_and_finish();
  end
endmodule : tcfc_timer_tb_top
bind tcfc_timer tcfc_timer_properties i_tcfc_timer_properties (.clock, .rst_b, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wait_mode,
  .port_oe, .accum_div64_tick, .irq);
